//--- src/fer_pkg.sv
// Purpose: shared constants and carriers for the 100 Mb/s receive decoder
// Assumes: one aligned code group per clock, printed bit 4 received first
// Notes:   register map, special code groups and timing counts live here only
package fer_pkg;

   // clocking and link-ready timing
   localparam int unsigned CLK_MHZ         = 200;
   localparam int unsigned LINK_READY_US   = 500;
   localparam int unsigned LINK_READY_CYC  = LINK_READY_US * CLK_MHZ;
   localparam int unsigned READY_CNT_W     = 17;

   // special code groups
   localparam logic [4:0]  CG_IDLE         = 5'h1f;
   localparam logic [4:0]  CG_J            = 5'h18;
   localparam logic [4:0]  CG_K            = 5'h11;
   localparam logic [4:0]  CG_T            = 5'h0d;
   localparam logic [4:0]  CG_R            = 5'h07;
   localparam logic [4:0]  CG_FAR_END_FAULT_IDLE_LAST    = 5'h1e;

   // substituted and error nibbles
   localparam logic [3:0]  NIB_PREAMBLE    = 4'h5;
   localparam logic [3:0]  NIB_BAD_SSD     = 4'he;
   localparam logic [3:0]  NIB_ZERO        = 4'h0;

   // far-end fault idle: 84 ones and a zero make 17 groups
   localparam logic [4:0]  FAR_END_FAULT_IDLE_GROUPS     = 5'h11;

   // raw history and carrier window
   localparam int unsigned WIN_W           = 10;
   localparam int unsigned HIST_W          = 14;
   localparam int unsigned NUM_WIN         = 5;

   // register map, byte addresses
   localparam logic [3:0]  ADDR_CTRL       = 4'h0;
   localparam logic [3:0]  ADDR_STATUS     = 4'h4;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
   localparam int unsigned CTRL_AN_DIS     = 0;
   localparam int unsigned CTRL_REPEATER   = 1;
   localparam int unsigned CTRL_FAR_END_FAULT_IDLE_TX    = 2;
   localparam int unsigned ST_LINK         = 0;
   localparam int unsigned ST_LINK100      = 1;
   localparam int unsigned ST_READY        = 2;
   localparam int unsigned ST_CARRIER      = 3;
   localparam int unsigned ST_BAD_SSD      = 4;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef struct packed {
      logic        awvalid;
      logic [3:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [3:0]  araddr;
      logic        rready;
   } fer_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } fer_axi_rsp_t;

   typedef struct packed {
      logic [3:0]  rxd;
      logic        rx_nibble_valid;
      logic        rx_code_error;
   } fer_mii_t;

endpackage

//--- src/fer_sym_lut.sv
// Purpose: fixed 5b to 4b code group lookup
// Assumes: code group printed with first received bit in bit 4
// Notes:   any pattern not in the data table reports invalid
`timescale 1ns/10ps
module fer_sym_lut (
   // code group in
   input  wire logic [4:0] i_code,
   // nibble out
   output logic       [3:0] o_nibble,
   output logic             o_valid
);

   always_comb begin
      o_valid  = 1'b1;
      case (i_code)
         5'h1e: o_nibble = 4'h0;
         5'h09: o_nibble = 4'h1;
         5'h14: o_nibble = 4'h2;
         5'h15: o_nibble = 4'h3;
         5'h0a: o_nibble = 4'h4;
         5'h0b: o_nibble = 4'h5;
         5'h0e: o_nibble = 4'h6;
         5'h0f: o_nibble = 4'h7;
         5'h12: o_nibble = 4'h8;
         5'h13: o_nibble = 4'h9;
         5'h16: o_nibble = 4'ha;
         5'h17: o_nibble = 4'hb;
         5'h1a: o_nibble = 4'hc;
         5'h1b: o_nibble = 4'hd;
         5'h1c: o_nibble = 4'he;
         5'h1d: o_nibble = 4'hf;
         default: begin
            o_nibble = 4'h0;
            o_valid  = 1'b0;
         end
      endcase
   end

endmodule

//--- src/fer_zero_pair.sv
// Purpose: finds two non-adjacent zeros inside one bit window
// Assumes: window is any contiguous slice of the raw stream
// Notes:   purely combinational, instanced once per window offset
`timescale 1ns/10ps
module fer_zero_pair #(
   parameter int unsigned WIDTH = 10
) (
   // window in
   input  wire logic [WIDTH-1:0] i_win,
   // detection out
   output logic                  o_hit
);

   always_comb begin
      o_hit = 1'b0;
      for (int i = 0; i < WIDTH; i++) begin
         for (int j = i + 2; j < WIDTH; j++) begin
            if (!i_win[i] && !i_win[j]) begin
               o_hit = 1'b1;
            end
         end
      end
   end

endmodule

//--- src/fer_rx_decode.sv
// Purpose: 100 Mb/s receive back end: decode, valid, error, carrier, link
// Assumes: aligned groups and raw groups arrive one per clock
// Notes:   control and status reached over an AXI4-Lite slave
`timescale 1ns/10ps
module fer_rx_decode #(
   parameter int unsigned P_READY_CYCLES = fer_pkg::LINK_READY_CYC
) (
   // clock and reset
   input  wire logic                  I_CLOCK,
   input  wire logic                  I_RST_N,
   // receive stream
   input  wire logic [4:0]            I_CODE_GROUP,
   input  wire logic [4:0]            I_RAW_GROUP,
   input  wire logic                  I_SIGNAL_DETECT,
   // surrounding status
   input  wire logic                  I_LINK10_OK,
   input  wire logic                  I_AN_LINK_ENABLE,
   input  wire logic                  I_TX_ACTIVE,
   input  wire logic                  I_REMOTE_FAULT,
   // register bus
   input  wire fer_pkg::fer_axi_req_t I_AXI,
   output fer_pkg::fer_axi_rsp_t      O_AXI,
   // internal mii
   output fer_pkg::fer_mii_t          O_MII,
   output logic                       O_CARRIER_PRESENT,
   // link and transmit idle
   output logic                       O_LINK_ACTIVITY_PIN,
   output logic                       O_TX_RX_ENABLE,
   output logic [4:0]                 O_TX_IDLE_GROUP
);
   import fer_pkg::*;

   typedef enum logic [1:0] {
      LNK_DOWN, LNK_WAIT, LNK_READY, LNK_UP
   } fer_link_t;

   typedef enum logic [2:0] {
      RX_IDLE, RX_SSD_K, RX_DATA, RX_ESD_R, RX_BAD
   } fer_rx_t;

   fer_link_t               link_q, link_d;
   logic [READY_CNT_W-1:0]  ready_cnt_q;
   fer_rx_t                 rx_q, rx_d;
   logic [4:0]              g1_q;
   logic                    prev_idle_q;
   logic [HIST_W-1:0]       hist_q, hist_d;
   logic [NUM_WIN-1:0]      win_hit;
   logic                    zero_hit, idle_pair;
   logic                    rx_crs_q, rx_crs_d;
   logic [3:0]              lut_nib, rxd_d;
   logic                    lut_ok;
   logic                    dv_d, err_d;
   logic                    link_ok;
   logic [31:0]             ctrl_q;
   logic [4:0]              far_end_fault_idle_cnt_q;
   logic                    aw_got_q, w_got_q;
   logic [3:0]              aw_addr_q, w_strb_q;
   logic [31:0]             w_data_q, status;

   // link monitor
   assign link_ok = I_SIGNAL_DETECT;

   always_comb begin
      link_d = link_q;
      case (link_q)
         LNK_DOWN: begin
            if (link_ok) begin
               link_d = LNK_WAIT;
            end
         end
         LNK_WAIT: begin
            if (!link_ok) begin
               link_d = LNK_DOWN;
            end else if (ready_cnt_q >= READY_CNT_W'(P_READY_CYCLES - 1)) begin
               link_d = LNK_READY;
            end
         end
         LNK_READY: begin
            if (!link_ok) begin
               link_d = LNK_DOWN;
            end else if (ctrl_q[CTRL_AN_DIS]) begin
               link_d = LNK_UP;
            end else if (I_AN_LINK_ENABLE) begin
               link_d = LNK_UP;
            end
         end
         LNK_UP: begin
            if (!link_ok) begin
               link_d = LNK_DOWN;
            end
         end
         default: link_d = LNK_DOWN;
      endcase
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         link_q      <= LNK_DOWN;
         ready_cnt_q <= '0;
      end else begin
         link_q <= link_d;
         // energy must persist the whole span, any gap restarts it
         if (link_q == LNK_WAIT && link_ok) begin
            ready_cnt_q <= ready_cnt_q + 1'b1;
         end else begin
            ready_cnt_q <= '0;
         end
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_TX_RX_ENABLE      <= 1'b0;
         O_LINK_ACTIVITY_PIN <= 1'b0;
      end else begin
         O_TX_RX_ENABLE      <= (link_d == LNK_UP);
         O_LINK_ACTIVITY_PIN <= (link_d == LNK_UP) | I_LINK10_OK;
      end
   end

   // carrier detect on the unaligned stream
   assign hist_d = {hist_q[HIST_W-6:0], I_RAW_GROUP};

   for (genvar k = 0; k < NUM_WIN; k++) begin : g_win
      fer_zero_pair #(
         .WIDTH (WIN_W)
      ) u_zp (
         .i_win (hist_d[k+WIN_W-1:k]),
         .o_hit (win_hit[k])
      );
   end

   assign zero_hit  = |win_hit;
   assign idle_pair = (g1_q == CG_IDLE) && prev_idle_q;

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         hist_q      <= '1;
         g1_q        <= CG_IDLE;
         prev_idle_q <= 1'b1;
      end else begin
         hist_q      <= hist_d;
         g1_q        <= I_CODE_GROUP;
         prev_idle_q <= (g1_q == CG_IDLE);
      end
   end

   // receive state, g1 is the group at hand and the input its lookahead
   fer_sym_lut u_lut (
      .i_code   (g1_q),
      .o_nibble (lut_nib),
      .o_valid  (lut_ok)
   );

   always_comb begin
      rx_d  = rx_q;
      rxd_d = NIB_ZERO;
      dv_d  = 1'b0;
      err_d = 1'b0;
      case (rx_q)
         RX_IDLE: begin
            if (g1_q == CG_J && I_CODE_GROUP == CG_K && prev_idle_q) begin
               rx_d  = RX_SSD_K;
               rxd_d = NIB_PREAMBLE;
               dv_d  = 1'b1;
            end else if (g1_q != CG_IDLE) begin
               rx_d  = RX_BAD;
               rxd_d = NIB_BAD_SSD;
               err_d = 1'b1;
            end
         end
         RX_SSD_K: begin
            rx_d  = RX_DATA;
            rxd_d = NIB_PREAMBLE;
            dv_d  = 1'b1;
         end
         RX_DATA: begin
            if (g1_q == CG_T && I_CODE_GROUP == CG_R) begin
               rx_d = RX_ESD_R;
            end else begin
               rxd_d = lut_nib;
               dv_d  = 1'b1;
               err_d = !lut_ok;
            end
         end
         RX_ESD_R: rx_d = RX_IDLE;
         RX_BAD: begin
            if (idle_pair) begin
               rx_d = RX_IDLE;
            end else begin
               rxd_d = NIB_BAD_SSD;
               err_d = 1'b1;
            end
         end
         default: rx_d = RX_IDLE;
      endcase
      // halted link or lost energy ends any frame at once
      if (link_q != LNK_UP) begin
         rx_d  = RX_IDLE;
         rxd_d = NIB_ZERO;
         dv_d  = 1'b0;
         err_d = 1'b0;
      end
   end

   // carrier held for any busy receive state so it encloses valid
   always_comb begin
      rx_crs_d = rx_crs_q;
      if (rx_d != RX_IDLE) begin
         rx_crs_d = 1'b1;
      end else if (zero_hit) begin
         rx_crs_d = 1'b1;
      end else if (idle_pair || rx_q == RX_BAD) begin
         rx_crs_d = 1'b0;
      end
      if (link_q != LNK_UP) begin
         rx_crs_d = 1'b0;
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rx_q              <= RX_IDLE;
         rx_crs_q          <= 1'b0;
         O_MII             <= '0;
         O_CARRIER_PRESENT <= 1'b0;
      end else begin
         rx_q                  <= rx_d;
         rx_crs_q              <= rx_crs_d;
         O_MII.rxd             <= rxd_d;
         O_MII.rx_nibble_valid <= dv_d;
         O_MII.rx_code_error   <= err_d;
         O_CARRIER_PRESENT     <= rx_crs_d |
                                  (!ctrl_q[CTRL_REPEATER] &&
                                   I_TX_ACTIVE && link_q == LNK_UP);
      end
   end

   // transmit idle source, far-end fault pattern when asked
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         far_end_fault_idle_cnt_q      <= '0;
         O_TX_IDLE_GROUP <= CG_IDLE;
      end else if (ctrl_q[CTRL_FAR_END_FAULT_IDLE_TX] && I_REMOTE_FAULT) begin
         if (far_end_fault_idle_cnt_q == FAR_END_FAULT_IDLE_GROUPS - 5'h01) begin
            far_end_fault_idle_cnt_q      <= '0;
            O_TX_IDLE_GROUP <= CG_FAR_END_FAULT_IDLE_LAST;
         end else begin
            far_end_fault_idle_cnt_q      <= far_end_fault_idle_cnt_q + 5'h01;
            O_TX_IDLE_GROUP <= CG_IDLE;
         end
      end else begin
         far_end_fault_idle_cnt_q      <= '0;
         O_TX_IDLE_GROUP <= CG_IDLE;
      end
   end

   // status word seen by software
   always_comb begin
      status              = '0;
      status[ST_LINK]     = (link_q == LNK_UP) | I_LINK10_OK;
      status[ST_LINK100]  = (link_q == LNK_UP);
      status[ST_READY]    = (link_q == LNK_READY);
      status[ST_CARRIER]  = rx_crs_q;
      status[ST_BAD_SSD]  = (rx_q == RX_BAD);
   end

   // axi4-lite write: address and data taken in either order
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         aw_addr_q     <= '0;
         w_data_q      <= '0;
         w_strb_q      <= '0;
         O_AXI.awready <= 1'b1;
         O_AXI.wready  <= 1'b1;
         O_AXI.bvalid  <= 1'b0;
         O_AXI.bresp   <= RESP_OKAY;
         ctrl_q        <= CTRL_RESET;
      end else begin
         if (I_AXI.awvalid && O_AXI.awready) begin
            aw_got_q      <= 1'b1;
            aw_addr_q     <= I_AXI.awaddr;
            O_AXI.awready <= 1'b0;
         end
         if (I_AXI.wvalid && O_AXI.wready) begin
            w_got_q      <= 1'b1;
            w_data_q     <= I_AXI.wdata;
            w_strb_q     <= I_AXI.wstrb;
            O_AXI.wready <= 1'b0;
         end
         if (aw_got_q && w_got_q && !O_AXI.bvalid) begin
            O_AXI.bvalid <= 1'b1;
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            if (aw_addr_q == ADDR_CTRL) begin
               O_AXI.bresp <= RESP_OKAY;
               // only the low byte holds control bits
               if (w_strb_q[0]) begin
                  ctrl_q[7:0] <= w_data_q[7:0];
               end
            end else if (aw_addr_q == ADDR_STATUS) begin
               O_AXI.bresp <= RESP_OKAY;
            end else begin
               O_AXI.bresp <= RESP_SLVERR;
            end
         end
         if (O_AXI.bvalid && I_AXI.bready) begin
            O_AXI.bvalid  <= 1'b0;
            O_AXI.awready <= 1'b1;
            O_AXI.wready  <= 1'b1;
         end
      end
   end

   // axi4-lite read
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_AXI.arready <= 1'b1;
         O_AXI.rvalid  <= 1'b0;
         O_AXI.rdata   <= '0;
         O_AXI.rresp   <= RESP_OKAY;
      end else begin
         if (I_AXI.arvalid && O_AXI.arready) begin
            O_AXI.arready <= 1'b0;
            O_AXI.rvalid  <= 1'b1;
            if (I_AXI.araddr == ADDR_CTRL) begin
               O_AXI.rdata <= {24'h000000, ctrl_q[7:0]};
               O_AXI.rresp <= RESP_OKAY;
            end else if (I_AXI.araddr == ADDR_STATUS) begin
               O_AXI.rdata <= status;
               O_AXI.rresp <= RESP_OKAY;
            end else begin
               O_AXI.rdata <= '0;
               O_AXI.rresp <= RESP_SLVERR;
            end
         end
         if (O_AXI.rvalid && I_AXI.rready) begin
            O_AXI.rvalid  <= 1'b0;
            O_AXI.arready <= 1'b1;
         end
      end
   end

endmodule

//--- verification/fer_rx_decode_assertions.sv
// Purpose: port-level checks on the receive decoder
// Assumes: one clock, asynchronous active-low reset
// Notes:   bus timing taken from the designer's hand-over
`timescale 1ns/10ps
module fer_rx_decode_assertions #(
   parameter int unsigned P_READY_CYCLES = fer_pkg::LINK_READY_CYC
) (
   // clock and reset
   input wire logic                  I_CLOCK,
   input wire logic                  I_RST_N,
   // watched inputs
   input wire logic                  I_SIGNAL_DETECT,
   input wire logic                  I_LINK10_OK,
   input wire fer_pkg::fer_axi_req_t I_AXI,
   // watched outputs
   input wire fer_pkg::fer_axi_rsp_t O_AXI,
   input wire fer_pkg::fer_mii_t     O_MII,
   input wire logic                  O_CARRIER_PRESENT,
   input wire logic                  O_LINK_ACTIVITY_PIN,
   input wire logic                  O_TX_RX_ENABLE,
   input wire logic [4:0]            O_TX_IDLE_GROUP
);
   import fer_pkg::*;
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!I_RST_N);
   // energy run length, restarts on any drop as the monitor must
   int unsigned sd_run_q;
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sd_run_q <= 0;
      end else begin
         sd_run_q <= I_SIGNAL_DETECT ? sd_run_q + 1 : 0;
      end
   end
   AST_VALID_IN_CARRIER: assert property (
      O_MII.rx_nibble_valid |-> O_CARRIER_PRESENT)
      else $error("nibble valid outside carrier");
   AST_PREAMBLE_PAIR: assert property (
      $rose(O_MII.rx_nibble_valid) |-> O_MII.rxd == NIB_PREAMBLE ##1
      (O_MII.rx_nibble_valid && O_MII.rxd == NIB_PREAMBLE))
      else $error("frame does not open with two preamble nibbles");
   AST_BAD_SSD_NIBBLE: assert property (
      O_MII.rx_code_error && !O_MII.rx_nibble_valid |->
      O_MII.rxd == NIB_BAD_SSD)
      else $error("bad start nibble wrong");
   AST_LOSS_HALTS: assert property (
      !I_SIGNAL_DETECT ##1 !I_SIGNAL_DETECT |=> !O_MII.rx_nibble_valid &&
      !O_MII.rx_code_error && !O_TX_RX_ENABLE)
      else $error("receive active without signal");
   AST_LINK10_PIN: assert property (
      I_LINK10_OK |=> O_LINK_ACTIVITY_PIN)
      else $error("activity pin ignores slow link");
   AST_READY_TIME: assert property (
      $rose(O_TX_RX_ENABLE) |-> sd_run_q >= P_READY_CYCLES)
      else $error("link up before ready time");
   AST_FAR_END_FAULT_IDLE_RUN: assert property (
      O_TX_IDLE_GROUP == CG_FAR_END_FAULT_IDLE_LAST |=> (O_TX_IDLE_GROUP == CG_IDLE)[*8])
      else $error("fault idle zero too soon");
   AST_W_ANSWER: assert property (
      I_AXI.awvalid && O_AXI.awready && I_AXI.wvalid && O_AXI.wready
      |-> ##[1:2] O_AXI.bvalid)
      else $error("write response missing");
   AST_R_ANSWER: assert property (
      I_AXI.arvalid && O_AXI.arready |=> O_AXI.rvalid)
      else $error("read response missing");
   AST_B_DONE: assert property (
      O_AXI.bvalid && I_AXI.bready |=> !O_AXI.bvalid && O_AXI.awready)
      else $error("write channel not released");
   AST_R_DONE: assert property (
      O_AXI.rvalid && I_AXI.rready |=> !O_AXI.rvalid && O_AXI.arready)
      else $error("read channel not released");
   COV_FRAME: cover property ($rose(O_MII.rx_nibble_valid));
   COV_BAD_SSD: cover property (O_MII.rx_code_error && !O_MII.rx_nibble_valid);
   COV_FAR_END_FAULT_IDLE: cover property (O_TX_IDLE_GROUP == CG_FAR_END_FAULT_IDLE_LAST);
endmodule

bind fer_rx_decode fer_rx_decode_assertions #(
   .P_READY_CYCLES(P_READY_CYCLES)
) u_fer_chk (
   .I_CLOCK            (I_CLOCK),
   .I_RST_N            (I_RST_N),
   .I_SIGNAL_DETECT    (I_SIGNAL_DETECT),
   .I_LINK10_OK        (I_LINK10_OK),
   .I_AXI              (I_AXI),
   .O_AXI              (O_AXI),
   .O_MII              (O_MII),
   .O_CARRIER_PRESENT  (O_CARRIER_PRESENT),
   .O_LINK_ACTIVITY_PIN(O_LINK_ACTIVITY_PIN),
   .O_TX_RX_ENABLE     (O_TX_RX_ENABLE),
   .O_TX_IDLE_GROUP    (O_TX_IDLE_GROUP)
);

//--- verification/fer_mac_sink.sv
// Purpose: switch-side model on the internal mii
// Assumes: receive units are flagged by valid or error
// Notes:   one cycle capture delay, order is kept
`timescale 1ns/10ps
module fer_mac_sink (
   // clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_rst_n,
   // mii from the decoder and transmit request
   input  wire fer_pkg::fer_mii_t i_mii,
   input  wire logic              i_tx_req,
   // captured unit and transmit state
   output logic                   o_hit,
   output logic [5:0]             o_word,
   output logic                   o_tx_active
);
   import fer_pkg::*;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_hit  <= 1'b0;
         o_word <= 6'h00;
      end else begin
         o_hit  <= i_mii.rx_nibble_valid | i_mii.rx_code_error;
         o_word <= {i_mii.rx_code_error, i_mii.rx_nibble_valid, i_mii.rxd};
      end
   end
   // transmit only while asked, no frame content modelled
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_tx_active <= 1'b0;
      end else begin
         o_tx_active <= i_tx_req;
      end
   end
endmodule

//--- verification/tb.sv
// Purpose: self-checking bench for the receive decoder
// Assumes: ready time shortened to 20 cycles
// Notes:   expected units queued by the driver, matched in order
`timescale 1ns/10ps
module tb;
   import fer_pkg::*;
   localparam int unsigned P = 20;
   localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a,
      5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b,
      5'h1c, 5'h1d};
   logic clk = 0, rst_n = 0, sd = 0, l10 = 0, anen = 0, rf = 0, txq = 0;
   logic mon_on = 1, carrier_present, lpin, en, hit, txa;
   logic [4:0] code = CG_IDLE, idg, rawm = 5'h1f;
   logic [5:0] word;
   logic [5:0] exp_q[$];
   fer_axi_req_t req = '0;
   fer_axi_rsp_t rsp;
   fer_mii_t mii;
   int err_total = 0, check_count = 0;
   always #2.5 clk = ~clk;
   fer_rx_decode #(.P_READY_CYCLES(P)) i_dut (.I_CLOCK(clk),
      .I_RST_N(rst_n), .I_CODE_GROUP(code), .I_RAW_GROUP(code & rawm),
      .I_SIGNAL_DETECT(sd), .I_LINK10_OK(l10), .I_AN_LINK_ENABLE(anen),
      .I_TX_ACTIVE(txa), .I_REMOTE_FAULT(rf), .I_AXI(req), .O_AXI(rsp),
      .O_MII(mii), .O_CARRIER_PRESENT(carrier_present), .O_LINK_ACTIVITY_PIN(lpin),
      .O_TX_RX_ENABLE(en), .O_TX_IDLE_GROUP(idg));
   fer_mac_sink i_mac (.i_clock(clk), .i_rst_n(rst_n), .i_mii(mii),
      .i_tx_req(txq), .o_hit(hit), .o_word(word), .o_tx_active(txa));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic stall();
      err_total++;
      conclude();
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   // one group per edge; only flagged units are queued
   task automatic send(input logic [4:0] g, input logic [5:0] e = 6'h00);
      @(posedge clk);
      code <= g;
      if (e[5:4] != 2'b00) exp_q.push_back(e);
   endtask
   function automatic logic [4:0] pick(input int s);
      return (s == 0) ? {4'h0, en} : (s == 1) ? {4'h0, carrier_present} : idg;
   endfunction
   task automatic await(input int s, input logic [4:0] v);
      int n;
      n = 0;
      while (n < 100 && pick(s) !== v) begin
         @(posedge clk);
         n++;
      end
      if (n == 100) stall();
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) begin
            req.bready <= 1'b0;
            chk(rsp.bresp, er);
            break;
         end
      end
      if (n == 50) stall();
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] ex,
                     input logic [31:0] m, input logic [1:0] er);
      int n;
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) begin
            req.rready <= 1'b0;
            chk(rsp.rdata & m, ex);
            chk(rsp.rresp, er);
            break;
         end
      end
      if (n == 50) stall();
   endtask
   task automatic frame(input bit rnd);
      logic [3:0] nb;
      send(CG_IDLE);
      send(CG_IDLE);
      send(CG_J, {2'b01, NIB_PREAMBLE});
      send(CG_K, {2'b01, NIB_PREAMBLE});
      for (int i = 0; i < 16; i++) begin
         nb = rnd ? 4'($urandom) : 4'(i);
         send(ENC[nb], {2'b01, nb});
      end
      if (rnd) send(5'h00, 6'h30);
      send(CG_T);
      send(CG_R);
      repeat (3) send(CG_IDLE);
   endtask
   // unit checker: any unexpected unit meets an empty mark
   always @(posedge clk) begin
      if (mon_on && hit) begin
         chk(word, exp_q.size() > 0 ? exp_q.pop_front() : 6'h00);
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      stall();
   end
   initial begin
      void'($urandom(32'hc3d8ef21));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk({lpin, en, carrier_present, mii}, 32'h0);
      chk(idg, CG_IDLE);
      rd(ADDR_CTRL, CTRL_RESET, 32'hffff_ffff, RESP_OKAY);
      done("reset");
      l10 <= 1'b1;
      repeat (3) @(posedge clk);
      chk(lpin, 1'b1);
      l10 <= 1'b0;
      sd <= 1'b1;
      repeat (P + 10) @(posedge clk);
      chk(en, 1'b0);
      rd(ADDR_STATUS, 32'h1 << ST_READY, 32'h7, RESP_OKAY);
      anen <= 1'b1;
      await(0, 5'h01);
      rd(ADDR_STATUS, 32'h3, 32'h3, RESP_OKAY);
      done("link");
      frame(1'b0);
      frame(1'b1);
      repeat (8) @(posedge clk);
      chk(carrier_present, 1'b0);
      chk(exp_q.size(), 0);
      done("frames");
      send(CG_IDLE);
      send(CG_IDLE);
      repeat (3) send(5'h0a, {2'b10, NIB_BAD_SSD});
      send(CG_IDLE, {2'b10, NIB_BAD_SSD});
      repeat (2) send(CG_IDLE);
      repeat (6) @(posedge clk);
      chk(carrier_present, 1'b0);
      chk(exp_q.size(), 0);
      done("bad_start");
      txq <= 1'b1;
      repeat (4) @(posedge clk);
      chk(carrier_present, 1'b1);
      wr(ADDR_CTRL, 32'h1 << CTRL_REPEATER, RESP_OKAY);
      repeat (4) @(posedge clk);
      chk(carrier_present, 1'b0);
      txq <= 1'b0;
      done("carrier_mode");
      wr(ADDR_CTRL, 32'h1 << CTRL_FAR_END_FAULT_IDLE_TX, RESP_OKAY);
      rf <= 1'b1;
      await(2, CG_FAR_END_FAULT_IDLE_LAST);
      for (int i = 1; i <= 17; i++) begin
         @(posedge clk);
         chk(idg, i == 17 ? CG_FAR_END_FAULT_IDLE_LAST : CG_IDLE);
      end
      rf <= 1'b0;
      done("fault_idle");
      wr(ADDR_STATUS, 32'hffff_ffff, RESP_OKAY);
      wr(4'h8, 32'hffff_ffff, RESP_SLVERR);
      rd(4'h8, 32'h0, 32'hffff_ffff, RESP_SLVERR);
      wr(ADDR_CTRL, 32'hffff_ffff, RESP_OKAY);
      rd(ADDR_CTRL, 32'h7, 32'hffff_ff07, RESP_OKAY);
      rd(ADDR_STATUS, 32'h3, 32'h3, RESP_OKAY);
      done("registers");
      wr(ADDR_CTRL, 32'h1 << CTRL_AN_DIS, RESP_OKAY);
      mon_on <= 1'b0;
      anen <= 1'b0;
      send(CG_J);
      send(CG_K);
      send(ENC[3]);
      sd <= 1'b0;
      repeat (4) send(ENC[4]);
      chk(mii.rx_nibble_valid, 1'b0);
      chk(en, 1'b0);
      send(CG_IDLE);
      sd <= 1'b1;
      await(0, 5'h01);
      repeat (4) @(posedge clk);
      mon_on <= 1'b1;
      done("signal_loss");
      rawm <= 5'h15;
      @(posedge clk);
      rawm <= 5'h1f;
      repeat (2) @(posedge clk);
      chk(carrier_present, 1'b1);
      repeat (4) @(posedge clk);
      chk(carrier_present, 1'b0);
      done("raw_carrier");
      conclude();
   end
endmodule
